/* File: bench/general_purpose_io_ports_tb.sv */
`timescale 1ns/10ps
module general_purpose_io_ports_tb;
   import gpio_pkg::*;
   logic sys_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   reg_req_t req = 18'h0;
   logic small_pkg = 1'b0;
   logic mask = 1'b1;
   logic [39:0] ext_en = 40'hFF_FF_FF_FF_FF;
   logic [39:0] ext_val = 40'h0;
   logic [39:0] aen = 40'h0;
   logic [39:0] aout = 40'h0;
   logic [39:0] pad_in;
   logic [39:0] alt_in;
   logic [4:0] vfetch = 5'h0;
   logic [4:0] irq;
   logic [7:0] rdata, d, v, m, a;
   logic wake;
   pad_ctrl_t pads;
   int n_fail = 0;
   int n_compared = 0;
   gpio_ports dut_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .req_i(req), .rdata_o(rdata),
      .small_pkg_i(small_pkg), .pad_in_i(pad_in), .pad_o(pads), .alt_out_en_i(aen),
      .alt_out_i(aout), .alt_in_o(alt_in), .cpu_irq_mask_i(mask), .vector_fetch_i(vfetch),
      .irq_req_o(irq), .wakeup_o(wake));
   pin_world world_u (.sys_clk_i(sys_clk_i), .pads_i(pads), .ext_en_i(ext_en),
      .ext_val_i(ext_val), .level_o(pad_in));
   initial begin
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   // ---------------------------
   // Bus and check helpers
   // ---------------------------
   function automatic logic [7:0] ra(input int p, input int k);
      return ADDR_PORT_A_DATA + 8'(3 * p + k);
   endfunction : ra
   // Input pins show alternate output if taken over, else the pin
   function automatic logic [7:0] rd_exp(input logic [7:0] dir, lat, pin, en, ao);
      return (dir & lat) | (~dir & ((en & ao) | (~en & pin)));
   endfunction : rd_exp
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge sys_clk_i);
         #1;
      end
   endtask : tick
   task automatic check(input string nm, input logic [39:0] seen, input logic [39:0] ex);
      n_compared++;
      if (seen !== ex) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, ex, seen);
      end
   endtask : check
   task automatic bus(input logic w, input logic [7:0] ad, input logic [7:0] wd);
      @(posedge sys_clk_i);
      req.addr <= ad;
      req.wdata <= wd;
      req.wr <= w;
      req.rd <= ~w;
      @(posedge sys_clk_i);
      req.wr <= 1'b0;
      req.rd <= 1'b0;
   endtask : bus
   task automatic rd_chk(input logic [7:0] ad, input logic [7:0] ex, input string nm);
      bus(1'b0, ad, 8'h00);
      #1;
      check(nm, 40'(rdata), 40'(ex));
   endtask : rd_chk
   task automatic report_and_stop();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : report_and_stop
   // ---------------------------
   // Scenarios
   // ---------------------------
   initial begin
      void'($urandom(82));
      tick(16);
      rst_n_i <= 1'b1;
      tick(2);
      for (int r = 0; r < 15; r++) rd_chk(ra(0, r), 8'h00, "reset");
      rd_chk(8'h35, 8'h00, "unmapped");
      for (int p = 0; p < 5; p++) begin
         v = 8'($urandom);
         d = 8'($urandom);
         m = 8'($urandom);
         a = 8'($urandom);
         // Port A pin 0 always takes the alternate read and open-drain high
         if (p == 0) begin
            m[0] = 1'b1;
            d[0] = 1'b1;
         end
         ext_val[8*p +: 8] <= v;
         bus(1'b1, ra(p, 0), d);
         rd_chk(ra(p, 0), v, "pin");
         aen[8*p +: 8] <= m;
         aout[8*p +: 8] <= a;
         rd_chk(ra(p, 0), rd_exp(8'h00, d, v, m, a), "alt");
         aen <= 40'h0;
         ext_en[8*p +: 8] <= 8'h00;
         bus(1'b1, ra(p, 2), 8'hFF);
         bus(1'b1, ra(p, 1), 8'hFF);
         rd_chk(ra(p, 0), rd_exp(8'hFF, d, v, 8'h00, 8'h00), "latch");
         check("out", 40'(pads.out[8*p +: 8]), 40'(d));
         check("oe_pp", 40'(pads.oe[8*p +: 8]), 40'hFF);
         check("alt_in", 40'(alt_in[8*p +: 8]), 40'(d));
         rd_chk(ra(p, 1), 8'hFF, "dir");
         bus(1'b1, ra(p, 2), 8'h00);
         tick(1);
         check("oe_od", 40'(pads.oe[8*p +: 8]), 40'(d ^ 8'hFF));
         bus(1'b1, ra(p, 1), 8'h00);
         ext_en[8*p +: 8] <= 8'hFF;
      end
      mask <= 1'b0;
      ext_val[0] <= 1'b0;
      bus(1'b1, ra(0, 2), 8'h01);
      rd_chk(ADDR_IRQ_ENABLE_BASE, 8'h01, "en");
      bus(1'b1, ADDR_EDGE_CTRL, 8'h01);
      tick(4);
      check("idle", 40'(irq), 40'h0);
      ext_val[0] <= 1'b1;
      for (int i = 0; i < 8 && irq[0] !== 1'b1; i++) tick(1);
      tick(1);
      check("irq", 40'(irq), 40'h01);
      check("wake", 40'(wake), 40'h1);
      vfetch <= 5'h01;
      tick(1);
      vfetch <= 5'h00;
      tick(2);
      check("fetch", 40'(irq), 40'h0);
      check("wake_clr", 40'(wake), 40'h0);
      mask <= 1'b1;
      ext_val[0] <= 1'b0;
      tick(4);
      ext_val[0] <= 1'b1;
      tick(6);
      check("masked", 40'(irq), 40'h0);
      rd_chk(ADDR_PENDING, 8'h01, "pend");
      bus(1'b1, ADDR_EDGE_CTRL, 8'h00);
      rd_chk(ADDR_PENDING, 8'h00, "clr");
      bus(1'b1, ra(0, 2), 8'h00);
      ext_val[0] <= 1'b0;
      tick(6);
      rd_chk(ADDR_PENDING, 8'h00, "no_irq");
      small_pkg <= 1'b1;
      bus(1'b1, ra(1, 1), 8'hFF);
      bus(1'b1, ra(1, 0), 8'h00);
      rd_chk(ra(1, 1), 8'h00, "abs_dir");
      rd_chk(ra(1, 0), 8'hFF, "abs_dat");
      bus(1'b1, ra(3, 1), 8'hFF);
      rd_chk(ra(3, 1), 8'h1F, "d_dir");
      check("pull", pads.pull_up & ABSENT_MASK, ABSENT_MASK);
      check("oe_abs", pads.oe & ABSENT_MASK, 40'h0);
      report_and_stop();
   end
   // Run needs about 200 cycles; a hang is cut well beyond that
   initial begin
      repeat (20000) @(posedge sys_clk_i);
      n_fail++;
      report_and_stop();
   end
endmodule : general_purpose_io_ports_tb

/* File: bench/pin_world.sv */
`timescale 1ns/10ps
module pin_world (
   input wire logic sys_clk_i,
   input wire gpio_pkg::pad_ctrl_t pads_i,
   input wire logic [39:0] ext_en_i,
   input wire logic [39:0] ext_val_i,
   output logic [39:0] level_o
);
   import gpio_pkg::*;
   // ---------------------------
   // Pin level resolution
   // ---------------------------
   logic [39:0] float_q = 40'h00_00_00_00_00;
   // Undriven lines toggle so a stale level never passes for a real one
   always_ff @(posedge sys_clk_i) begin
      float_q <= ~float_q;
   end
   // Device drive first, then outside drive, then pull-up, else floating
   assign level_o = (pads_i.oe & pads_i.out) | (~pads_i.oe & ext_en_i & ext_val_i)
      | (~pads_i.oe & ~ext_en_i & (pads_i.pull_up | float_q));
endmodule : pin_world

/* File: core/gpio_ports.sv */
`timescale 1ns/10ps
module gpio_ports (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire gpio_pkg::reg_req_t req_i,
   output logic [7:0] rdata_o,
   input wire logic small_pkg_i,
   input wire logic [39:0] pad_in_i,
   output gpio_pkg::pad_ctrl_t pad_o,
   input wire logic [39:0] alt_out_en_i,
   input wire logic [39:0] alt_out_i,
   output logic [39:0] alt_in_o,
   input wire logic cpu_irq_mask_i,
   input wire logic [4:0] vector_fetch_i,
   output logic [4:0] irq_req_o,
   output logic wakeup_o
);
   import gpio_pkg::*;

   // ---------------------------------------------
   // Registers
   // ---------------------------------------------
   logic [39:0] data_q, dir_q, opt_q;
   logic [39:0] sync1_q, sync2_q, prev_q;
   logic [4:0] pend_q;
   logic [4:0] edge_q;
   logic [39:0] absent;
   logic [39:0] in_mode, irq_cap, ev;
   logic [7:0] rd_d;
   logic [7:0] idx;

   assign absent = small_pkg_i ? ABSENT_MASK : 40'h00_00_00_00_00;
   assign idx = req_i.addr - ADDR_PORT_A_DATA;

   function automatic logic in_map(input logic [7:0] a);
      in_map = (a >= ADDR_PORT_A_DATA) && (a <= ADDR_PORT_E_OPTION);
   endfunction : in_map

   function automatic logic wr_hit(input reg_req_t r, input logic [7:0] ad);
      wr_hit = r.wr && (r.addr == ad);
   endfunction : wr_hit

   // ---------------------------------------------
   // Port registers
   // ---------------------------------------------
   genvar p;
   generate
      for (p = 0; p < NUM_PORTS; p++) begin : g_port
         localparam logic [7:0] BASE = 8'(3 * p);
         always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               data_q[8*p +: 8] <= REG_RESET;
               dir_q[8*p +: 8] <= REG_RESET;
               opt_q[8*p +: 8] <= REG_RESET;
            end else begin
               // Writes land regardless of direction
               if (wr_hit(req_i, ADDR_PORT_A_DATA + BASE)) begin
                  data_q[8*p +: 8] <= req_i.wdata & ~absent[8*p +: 8];
               end else begin
                  data_q[8*p +: 8] <= data_q[8*p +: 8] & ~absent[8*p +: 8];
               end
               if (wr_hit(req_i, ADDR_PORT_A_DATA + BASE + 8'h01)) begin
                  dir_q[8*p +: 8] <= req_i.wdata & ~absent[8*p +: 8];
               end else begin
                  dir_q[8*p +: 8] <= dir_q[8*p +: 8] & ~absent[8*p +: 8];
               end
               if (wr_hit(req_i, ADDR_PORT_A_DATA + BASE + 8'h02)) begin
                  opt_q[8*p +: 8] <= req_i.wdata & OPTION_PRESENT;
               end
            end
         end
      end
   endgenerate

   // ---------------------------------------------
   // Pin synchroniser
   // ---------------------------------------------
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync1_q <= '0;
         sync2_q <= '0;
         prev_q <= '0;
      end else begin
         sync1_q <= pad_in_i;
         sync2_q <= sync1_q;
         prev_q <= sync2_q;
      end
   end

   // ---------------------------------------------
   // Pad drive
   // ---------------------------------------------
   // Alternate output overrides the port programming
   logic [39:0] drv_val, drv_en;
   always_comb begin
      for (int i = 0; i < 40; i++) begin
         drv_val[i] = alt_out_en_i[i] ? alt_out_i[i] : data_q[i];
      end
   end
   assign drv_en = dir_q | alt_out_en_i;

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pad_o <= '0;
         alt_in_o <= '0;
      end else begin
         pad_o.out <= drv_val & ~absent;
         // Open drain releases the high side on a one
         pad_o.oe <= drv_en & ~absent & (opt_q | alt_out_en_i | ~drv_val);
         pad_o.pull_up <= absent;
         // Output pins feed peripherals from the latch
         alt_in_o <= (dir_q & data_q) | (~dir_q & sync2_q);
      end
   end

   // ---------------------------------------------
   // Read back
   // ---------------------------------------------
   always_comb begin
      rd_d = 8'h00;
      for (int q = 0; q < NUM_PORTS; q++) begin
         if (idx == 8'(3 * q)) begin
            for (int b = 0; b < 8; b++) begin
               if (absent[8*q+b]) rd_d[b] = 1'b1;
               else if (!dir_q[8*q+b] && alt_out_en_i[8*q+b])
                  rd_d[b] = alt_out_i[8*q+b];
               else if (!dir_q[8*q+b]) rd_d[b] = sync2_q[8*q+b];
               else rd_d[b] = data_q[8*q+b];
            end
         end else if (idx == 8'(3 * q + 1)) begin
            rd_d = dir_q[8*q +: 8];
         end else if (idx == 8'(3 * q + 2)) begin
            rd_d = opt_q[8*q +: 8];
         end
      end
      if (!in_map(req_i.addr)) rd_d = 8'h00;
      for (int q = 0; q < NUM_PORTS; q++) begin
         if (req_i.addr == ADDR_IRQ_ENABLE_BASE + 8'(q)) rd_d = opt_q[8*q +: 8];
      end
      if (req_i.addr == ADDR_EDGE_CTRL) rd_d = {3'b000, edge_q};
      if (req_i.addr == ADDR_PENDING) rd_d = {3'b000, pend_q};
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= 8'h00;
      end else if (req_i.rd) begin
         rdata_o <= rd_d;
      end else begin
         // Idle bus reads zero so stale data never looks valid
         rdata_o <= 8'h00;
      end
   end

   // ---------------------------------------------
   // Pin interrupts
   // ---------------------------------------------
   // Enable bits share option storage: input with option set is interrupt capable
   assign in_mode = ~dir_q & ~absent;
   assign irq_cap = in_mode & opt_q;
   logic edge_wr;
   assign edge_wr = wr_hit(req_i, ADDR_EDGE_CTRL) && (req_i.wdata[4:0] != edge_q);

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         edge_q <= 5'h00;
      end else if (wr_hit(req_i, ADDR_EDGE_CTRL)) begin
         edge_q <= req_i.wdata[4:0];
      end
   end

   always_comb begin
      for (int i = 0; i < 40; i++) begin
         // Edge_q bit 1 selects rising, 0 falling, per port vector
         ev[i] = irq_cap[i] & (edge_q[i/8] ? (sync2_q[i] & ~prev_q[i])
                                             : (~sync2_q[i] & prev_q[i]));
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pend_q <= 5'h00;
      end else begin
         for (int q = 0; q < NUM_PORTS; q++) begin
            if (edge_wr) pend_q[q] <= 1'b0;
            else if (|ev[8*q +: 8]) pend_q[q] <= 1'b1;
            else if (vector_fetch_i[q]) pend_q[q] <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_req_o <= 5'h00;
         wakeup_o <= 1'b0;
      end else begin
         irq_req_o <= cpu_irq_mask_i ? 5'h00 : pend_q;
         // Wake ignores the CPU mask; low power never touches port state
         wakeup_o <= |pend_q;
      end
   end

   // ---------------------------------------------
   // Checks
   // ---------------------------------------------
   property p_rst_data;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      $rose(rst_n_i) |-> data_q == '0;
   endproperty
   a_rst_data: assert property (p_rst_data) else $error("data not reset");

   property p_irq_mask;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      $past(cpu_irq_mask_i) |-> irq_req_o == 5'h00;
   endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");

   property p_edge_clear;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      edge_wr |=> pend_q == 5'h00;
   endproperty
   a_edge_clear: assert property (p_edge_clear) else $error("pending kept");

   property p_absent_zero;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      small_pkg_i ##1 small_pkg_i |-> (dir_q & ABSENT_MASK) == '0;
   endproperty
   a_absent_zero: assert property (p_absent_zero) else $error("absent dir set");

   property p_wr_data;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      req_i.wr && req_i.addr == ADDR_PORT_A_DATA && !small_pkg_i
      |=> data_q[7:0] == $past(req_i.wdata);
   endproperty
   a_wr_data: assert property (p_wr_data) else $error("latch missed write");

   property p_pull;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      small_pkg_i |=> pad_o.pull_up == ABSENT_MASK && (pad_o.oe & ABSENT_MASK) == '0;
   endproperty
   a_pull: assert property (p_pull) else $error("absent pin not pulled");

   property p_fetch;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      vector_fetch_i[0] && ev[7:0] == '0 && !edge_wr |=> !pend_q[0];
   endproperty
   a_fetch: assert property (p_fetch) else $error("fetch did not clear");

   property p_od;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      dir_q[0] && !opt_q[0] && !alt_out_en_i[0] && data_q[0] && !small_pkg_i
      |=> !pad_o.oe[0];
   endproperty
   a_od: assert property (p_od) else $error("open drain drove high");

   // ---------------------------------------------
   // Checks on registers, read back, pads and requests
   // ---------------------------------------------
   property p_rst_dir;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      $rose(rst_n_i) |-> dir_q == '0 && opt_q == '0;
   endproperty
   a_rst_dir: assert property (p_rst_dir) else $error("direction not reset");

   property p_rst_pads;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      $rose(rst_n_i) |-> pad_o.oe == '0 && rdata_o == 8'h00;
   endproperty
   a_rst_pads: assert property (p_rst_pads) else $error("pads driven after reset");

   property p_rd_absent;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      req_i.rd && small_pkg_i && req_i.addr == ADDR_PORT_B_DATA |=> rdata_o == 8'hFF;
   endproperty
   a_rd_absent: assert property (p_rd_absent) else $error("absent data not one");

   property p_rd_out;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      req_i.rd && req_i.addr == ADDR_PORT_A_DATA && dir_q[0] |=> rdata_o[0] == $past(data_q[0]);
   endproperty
   a_rd_out: assert property (p_rd_out) else $error("output read not latch");

   property p_rd_in;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      req_i.rd && req_i.addr == ADDR_PORT_A_DATA && !dir_q[0] && !alt_out_en_i[0]
      |=> rdata_o[0] == $past(sync2_q[0]);
   endproperty
   a_rd_in: assert property (p_rd_in) else $error("input read not pin");

   property p_rd_alt;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      req_i.rd && req_i.addr == ADDR_PORT_A_DATA && !dir_q[0] && alt_out_en_i[0]
      |=> rdata_o[0] == $past(alt_out_i[0]);
   endproperty
   a_rd_alt: assert property (p_rd_alt) else $error("alternate read wrong");

   property p_alt_in_out;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      dir_q[0] |=> alt_in_o[0] == $past(data_q[0]);
   endproperty
   a_alt_in_out: assert property (p_alt_in_out) else $error("peripheral not fed latch");

   property p_alt_in_in;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      !dir_q[0] |=> alt_in_o[0] == $past(sync2_q[0]);
   endproperty
   a_alt_in_in: assert property (p_alt_in_in) else $error("peripheral not fed pin");

   property p_pp;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      dir_q[0] && opt_q[0] |=> pad_o.oe[0];
   endproperty
   a_pp: assert property (p_pp) else $error("push-pull not driven");

   property p_in_float;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      !dir_q[0] && !alt_out_en_i[0] |=> !pad_o.oe[0];
   endproperty
   a_in_float: assert property (p_in_float) else $error("input pin driven");

   property p_no_cap;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      irq_cap[7:0] == '0 && !pend_q[0] |=> !pend_q[0];
   endproperty
   a_no_cap: assert property (p_no_cap) else $error("request without capability");

   property p_wake;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (|pend_q) |=> wakeup_o;
   endproperty
   a_wake: assert property (p_wake) else $error("pending without wake");

   property p_unmask;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      !cpu_irq_mask_i |=> irq_req_o == $past(pend_q);
   endproperty
   a_unmask: assert property (p_unmask) else $error("unmasked request lost");

   property p_hold_dir;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      !req_i.wr && !small_pkg_i |=> $stable(dir_q);
   endproperty
   a_hold_dir: assert property (p_hold_dir) else $error("direction moved");

   property p_absent_data;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      small_pkg_i ##1 small_pkg_i |-> (data_q & ABSENT_MASK) == '0;
   endproperty
   a_absent_data: assert property (p_absent_data) else $error("absent latch set");

   property p_no_pull;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      !small_pkg_i |=> pad_o.pull_up == '0;
   endproperty
   a_no_pull: assert property (p_no_pull) else $error("pull-up on bonded pin");
endmodule : gpio_ports

/* File: shared/gpio_pkg.sv */
// Contract
// - Input pin with alternate output enabled reads back the alternate output state.
// - Output pin with alternate input makes the peripheral see the latch level.
// - Wait and halt leave registers and pins unchanged; enabled pin interrupt wakes.
// - Pin event requests interrupt only if input, enabled, and CPU mask cleared.
// - Output option 0 is open drain, 1 is push-pull.
// - Input option 0 is plain floating, 1 is floating with interrupt.
// - Small package forces PB7:0, PD7:5, PE6:4 to input with pull-up.
// - Five ports A to E each have an 8-bit data latch reset to zero.
// - Data latch writes always update the latch, even for input pins.
// - Reading data of an input pin returns the synchronised pin level.
// - Small package: data bits of absent pins read as one.
// - Small package: direction and latch bits of absent pins held zero.
// - Each port has an 8-bit direction register, reset zero, 1 is output.
// - Pins without option storage are configured by direction alone.
// - Reading data of an output pin returns the latch, not the pin.
// - Bit x of each port register controls and reports pin x.
// - A latched pin interrupt request clears when its vector is fetched.
// - A write changing edge sensitivity clears all pending pin requests.
package gpio_pkg;
   localparam int NUM_PORTS = 5;
   localparam logic [7:0] ADDR_PORT_A_DATA = 8'h26;
   localparam logic [7:0] ADDR_PORT_A_DIR = 8'h27;
   localparam logic [7:0] ADDR_PORT_A_OPTION = 8'h28;
   localparam logic [7:0] ADDR_PORT_B_DATA = 8'h29;
   localparam logic [7:0] ADDR_PORT_B_DIR = 8'h2A;
   localparam logic [7:0] ADDR_PORT_B_OPTION = 8'h2B;
   localparam logic [7:0] ADDR_PORT_C_DATA = 8'h2C;
   localparam logic [7:0] ADDR_PORT_C_DIR = 8'h2D;
   localparam logic [7:0] ADDR_PORT_C_OPTION = 8'h2E;
   localparam logic [7:0] ADDR_PORT_D_DATA = 8'h2F;
   localparam logic [7:0] ADDR_PORT_D_DIR = 8'h30;
   localparam logic [7:0] ADDR_PORT_D_OPTION = 8'h31;
   localparam logic [7:0] ADDR_PORT_E_DATA = 8'h32;
   localparam logic [7:0] ADDR_PORT_E_DIR = 8'h33;
   localparam logic [7:0] ADDR_PORT_E_OPTION = 8'h34;
   localparam logic [7:0] ADDR_IRQ_ENABLE_BASE = 8'h40;
   localparam logic [7:0] ADDR_EDGE_CTRL = 8'h45;
   localparam logic [7:0] ADDR_PENDING = 8'h46;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] OPTION_PRESENT = 8'hFF;
   // Absent pins in the small package, indexed A..E
   localparam logic [39:0] ABSENT_MASK = 40'h70_E0_00_FF_00;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   typedef struct packed {
      logic [39:0] out;
      logic [39:0] oe;
      logic [39:0] pull_up;
   } pad_ctrl_t;
endpackage : gpio_pkg
